//--- fwsc_chk.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Checker on the alert pins, state code and serial data enable.
module fwsc_chk
  import fwsc_pkg::*;
#(
  parameter int RAMP_CYC = RAMP_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclPin,
  input wire logic muteN,
  input wire logic chOverCurrent,
  input wire logic clockError,
  input wire logic sdaPinOe,
  input wire logic errorAlertNOe,
  input wire logic cautionAlertNOe,
  input wire logic [2:0] opState
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Cycles spent so far in the ramp-down state.
  int rampCnt;
  always_ff @(posedge clk) begin
    if (sys_rst || opState != ST_RAMP) begin
      rampCnt <= 0;
    end else begin
      rampCnt <= rampCnt + 1;
    end
  end
  property p_errSet;
    (clockError && opState != ST_STANDBY) [*6] |-> errorAlertNOe;
  endproperty
  a_errSet: assert property (p_errSet)
    else $error("error pin missed");
  property p_errHold;
    $fell(errorAlertNOe) |-> !clockError && !$past(clockError, 6);
  endproperty
  a_errHold: assert property (p_errHold)
    else $error("error pin dropped");
  property p_cauHold;
    $fell(cautionAlertNOe) |-> !sclPin;
  endproperty
  a_cauHold: assert property (p_cauHold)
    else $error("caution dropped");
  property p_porWarn;
    $fell(sys_rst) |-> cautionAlertNOe;
  endproperty
  a_porWarn: assert property (p_porWarn)
    else $error("no reset warning");
  property p_chanHiz;
    $rose(chOverCurrent) && opState == ST_PLAY |-> ##[1:8] opState == ST_HIZ;
  endproperty
  a_chanHiz: assert property (p_chanHiz)
    else $error("no Hi-Z on fault");
  property p_mute;
    (!muteN) [*6] |-> opState != ST_PLAY;
  endproperty
  a_mute: assert property (p_mute)
    else $error("playing while muted");
  property p_rampLen;
    rampCnt <= RAMP_CYC + 1;
  endproperty
  a_rampLen: assert property (p_rampLen)
    else $error("ramp too long");
  property p_sdaStable;
    sclPin [*2] |-> $stable(sdaPinOe);
  endproperty
  a_sdaStable: assert property (p_sdaStable)
    else $error("data moved");
endmodule // fwsc_chk

bind fwsc_status_ctrl fwsc_chk #(.RAMP_CYC(RAMP_CYC)) u_fwsc_chk (.clk,
  .sys_rst, .sclPin, .muteN, .chOverCurrent, .clockError, .sdaPinOe,
  .errorAlertNOe, .cautionAlertNOe, .opState);
`default_nettype wire

//--- fwsc_clip_det.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Counts consecutive PWM clocks at full modulation.
module fwsc_clip_det (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pwmEdge,
  input wire logic atMax,
  input wire logic [7:0] window,
  output logic clipNow
);
  // Run length, saturating so long clips never wrap.
  logic [7:0] cnt_q;

  // Any PWM period below full modulation restarts the run.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= 8'h00;
    end else if (!atMax) begin
      cnt_q <= 8'h00;
    end else if (pwmEdge && cnt_q != 8'hFF) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // Clipping stands while the run has reached the window.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clipNow <= 1'b0;
    end else begin
      clipNow <= atMax && (cnt_q >= window);
    end
  end
endmodule // fwsc_clip_det
`default_nettype wire

//--- fwsc_i2c_host.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Behavioural bus controller; the clock idles high between frames.
module fwsc_i2c_host (
  output logic scl,
  output logic sdaLow,
  input wire logic sda
);
  // Quarter of the 125 ns link clock period.
  localparam realtime Q = 31.25;
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    sdaLow = 1'b0;
    #Q scl = 1'b1;
    #Q sdaLow = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  // Stop ends every frame after its last byte.
  task automatic stop();
    sdaLow = 1'b1;
    #Q scl = 1'b1;
    #Q sdaLow = 1'b0;
    #Q;
  endtask
  // One bit: data moves only while the clock is low.
  task automatic bitx(input logic b, output logic r);
    sdaLow = !b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  // One byte, most significant bit first, then the acknowledge slot.
  task automatic xfer(input logic [7:0] d, input logic ackIn,
      output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
      q[i] = r;
    end
    bitx(ackIn, r);
    ack = !r;
  endtask
endmodule // fwsc_i2c_host
`default_nettype wire

//--- fwsc_pkg.sv
// =====================================================================
// Shared constants and types of the fault and warning status block.
package fwsc_pkg;

  // Core clock rate and the standby ramp limit.
  localparam int CLK_MHZ = 125;
  localparam int RAMP_TIME_US = 5000;
  // Longest ramp in cycles, rounded down.
  localparam int RAMP_CYCLES = RAMP_TIME_US * CLK_MHZ;

  // Write address of target 0; the pins add 2 per step.
  localparam logic [7:0] WR_ADDR_BASE = 8'hD4;

  // Register offsets.
  localparam logic [7:0] REG_MISC1 = 8'h01;
  localparam logic [7:0] REG_STATE = 8'h04;
  localparam logic [7:0] REG_CHREP = 8'h0F;
  localparam logic [7:0] REG_CHFLT = 8'h10;
  localparam logic [7:0] REG_GFLT1 = 8'h11;
  localparam logic [7:0] REG_GFLT2 = 8'h12;
  localparam logic [7:0] REG_WARN = 8'h13;
  localparam logic [7:0] REG_PINCTL = 8'h14;
  localparam logic [7:0] REG_MISC3 = 8'h21;
  localparam logic [7:0] REG_CLIPCTL = 8'h22;
  localparam logic [7:0] REG_CLIPWIN = 8'h23;
  localparam logic [7:0] REG_CLIPWRN = 8'h24;
  localparam logic [7:0] REG_ILIM = 8'h25;

  // Values after reset.
  localparam logic [7:0] MISC1_RST = 8'h32;
  localparam logic [7:0] STATE_RST = 8'h00;
  localparam logic [7:0] PINCTL_RST = 8'h00;
  localparam logic [7:0] MISC3_RST = 8'h00;
  localparam logic [7:0] CLIPCTL_RST = 8'h00;
  localparam logic [7:0] CLIPWIN_RST = 8'h14;

  // Field positions.
  localparam int MISC3_CLEAR_BIT = 7;
  localparam int MISC3_AUTOREC_BIT = 3;
  localparam int MISC1_CAPLVL_BIT = 4;
  localparam int MISC1_OTW_LO = 5;
  localparam int CLIPCTL_NONLATCH_BIT = 0;
  localparam int PM_CHAN = 0;
  localparam int PM_OVERTEMP_SHUTDOWN = 1;
  localparam int PM_VOLT = 2;
  localparam int PM_CLK = 3;
  localparam int PM_CLIP = 4;
  localparam int PM_OTW = 5;
  localparam int PM_ILIM = 6;

  // Commanded channel state codes.
  localparam logic [1:0] CMD_PLAY = 2'h0;
  localparam logic [1:0] CMD_HIZ = 2'h1;
  localparam logic [1:0] CMD_MUTE = 2'h2;

  // Operating states.
  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_HIZ = 3'b001,
    ST_MUTE = 3'b010,
    ST_PLAY = 3'b011,
    ST_RAMP = 3'b100
  } fwsc_op_t;

  // Serial target phases.
  typedef enum logic [2:0] {
    IS_IDLE = 3'b000,
    IS_ADDR = 3'b001,
    IS_SUB = 3'b010,
    IS_WDATA = 3'b011,
    IS_ACK = 3'b100,
    IS_RDATA = 3'b101,
    IS_RACK = 3'b110
  } fwsc_i2c_t;

endpackage

//--- fwsc_status_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Fault, warning and operating state control with a serial target.
module fwsc_status_ctrl
  import fwsc_pkg::*;
#(
  parameter int RAMP_CYC = RAMP_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclPin,
  input wire logic sdaPinIn,
  output logic sdaPinO,
  output logic sdaPinOe,
  input wire logic [1:0] addressSelectPins,
  input wire logic muteN,
  input wire logic standbyN,
  input wire logic chOverCurrent,
  input wire logic chDcDetect,
  input wire logic overtempShutdown,
  input wire logic uvBatterySupply,
  input wire logic uvOutputStageSupply,
  input wire logic ovBatterySupply,
  input wire logic ovOutputStageSupply,
  input wire logic clockError,
  input wire logic otCautionGlobal,
  input wire logic otCautionChan,
  input wire logic currentCapFlag,
  input wire logic pwmClk,
  input wire logic pwmAtMax,
  output logic errorAlertNO,
  output logic errorAlertNOe,
  output logic cautionAlertNO,
  output logic cautionAlertNOe,
  output logic [2:0] opState,
  output logic outputsHiZ,
  output logic outputsMute,
  output logic rampDown,
  output logic oscRun,
  output logic [1:0] otwThreshold,
  output logic currentCapLevel
);
  localparam int RW = $clog2(RAMP_CYC + 1);

  // ===================================================================
  // Pin synchronisation
  // ===================================================================
  logic [18:0] pinRaw; // Raw pin levels.
  logic [18:0] pinS; // Synchronised pin levels.
  assign pinRaw = {sclPin, sdaPinIn, addressSelectPins, muteN,
                   standbyN, chOverCurrent, chDcDetect,
                   overtempShutdown, uvBatterySupply,
                   uvOutputStageSupply, ovBatterySupply,
                   ovOutputStageSupply, clockError, otCautionGlobal,
                   otCautionChan, currentCapFlag, pwmClk, pwmAtMax};

  fwsc_sync #(.WIDTH(19)) uSync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(pinRaw),
    .dout(pinS)
  );

  logic sclS, sdaS, muteNS, stbyNS, pwmS, atMaxS;
  logic ocS, dcS, otsdS, uvbS, uvoS, ovbS, ovoS, clkErrS;
  logic otwgS, otwcS, capS;
  logic [1:0] addrS;
  assign {sclS, sdaS, addrS, muteNS, stbyNS, ocS, dcS, otsdS,
          uvbS, uvoS, ovbS, ovoS, clkErrS, otwgS, otwcS, capS,
          pwmS, atMaxS} = pinS;

  // Previous samples for edge detection.
  logic sclD_q, sdaD_q, pwmD_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclD_q <= 1'b0;
      sdaD_q <= 1'b0;
      pwmD_q <= 1'b0;
    end else begin
      sclD_q <= sclS;
      sdaD_q <= sdaS;
      pwmD_q <= pwmS;
    end
  end

  // ===================================================================
  // Register file
  // ===================================================================
  logic [7:0] misc1_q, stateCtl_q, pinCtl_q, misc3_q;
  logic [7:0] clipCtl_q, clipWin_q;
  logic wrEn_q; // One-cycle write strobe from the serial side.
  logic [7:0] wrAddr_q, wrData_q;
  logic errorClear; // Clear pulse for all latched reports.

  // Software writes; the clear bit is never stored.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      misc1_q <= MISC1_RST;
      stateCtl_q <= STATE_RST;
      pinCtl_q <= PINCTL_RST;
      misc3_q <= MISC3_RST;
      clipCtl_q <= CLIPCTL_RST;
      clipWin_q <= CLIPWIN_RST;
    end else if (wrEn_q) begin
      case (wrAddr_q)
        REG_MISC1: misc1_q <= wrData_q;
        REG_STATE: stateCtl_q <= wrData_q;
        REG_PINCTL: pinCtl_q <= wrData_q;
        REG_MISC3: misc3_q <= {1'b0, wrData_q[6:0]};
        REG_CLIPCTL: clipCtl_q <= wrData_q;
        REG_CLIPWIN: clipWin_q <= wrData_q;
        default: ;
      endcase
    end
  end

  // A write of one to the clear bit yields exactly one pulse.
  assign errorClear = wrEn_q && (wrAddr_q == REG_MISC3) &&
                      wrData_q[MISC3_CLEAR_BIT];

  logic autoRec;
  assign autoRec = misc3_q[MISC3_AUTOREC_BIT];
  assign otwThreshold = misc1_q[MISC1_OTW_LO+1:MISC1_OTW_LO];
  assign currentCapLevel = misc1_q[MISC1_CAPLVL_BIT];

  // ===================================================================
  // Event monitoring
  // ===================================================================
  fwsc_op_t opState_q, opState_d;
  logic live, drive;
  // Global events and the channel overtemperature caution watched outside standby, other channel ones while switching.
  assign live = (opState_q != ST_STANDBY);
  assign drive = (opState_q == ST_MUTE) || (opState_q == ST_PLAY) ||
                 (opState_q == ST_RAMP);

  logic ocEv, dcEv, otsdEv, voltEv, clkEv, otwEv, capEv, clipNow;
  assign ocEv = ocS && drive;
  assign dcEv = dcS && drive;
  assign otsdEv = otsdS && live;
  assign voltEv = (uvbS || uvoS || ovbS || ovoS) && live;
  assign clkEv = clkErrS && live;
  assign otwEv = (otwgS || otwcS) && live;
  assign capEv = capS && drive;

  fwsc_clip_det uClip (
    .clk(clk),
    .sys_rst(sys_rst),
    .pwmEdge(pwmS && !pwmD_q),
    .atMax(atMaxS),
    .window(clipWin_q),
    .clipNow(clipNow)
  );

  // ===================================================================
  // Latched status
  // ===================================================================
  logic [10:0] stat_q; // Sticky fault and warning bits.
  logic [10:0] statRaw;
  logic porStat_q, clipStat_q;
  assign statRaw = {capEv, otwcS && live, otwgS && live, otsdEv,
                    clkEv, ovoS && live, ovbS && live, uvoS && live,
                    uvbS && live, dcEv, ocEv};

  // A standing condition wins over a clear in the same cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_q <= 11'h000;
    end else begin
      stat_q <= statRaw | (stat_q & ~{11{errorClear}});
    end
  end

  // Power-on leaves its warning bit set until cleared.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      porStat_q <= 1'b1;
    end else if (errorClear) begin
      porStat_q <= 1'b0;
    end
  end

  // Clip bit sticks in latching mode, follows the detector otherwise.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clipStat_q <= 1'b0;
    end else if (clipCtl_q[CLIPCTL_NONLATCH_BIT]) begin
      clipStat_q <= clipNow;
    end else begin
      clipStat_q <= clipNow || (clipStat_q && !errorClear);
    end
  end

  // ===================================================================
  // Alert pins
  // ===================================================================
  logic errOther_q, errOtsd_q, caution_q, otRelease;
  logic errSet;
  // Masks only stop new pin assertions; status is unaffected.
  assign errSet = (ocEv || dcEv) && !pinCtl_q[PM_CHAN] ||
                  voltEv && !pinCtl_q[PM_VOLT] ||
                  clkEv && !pinCtl_q[PM_CLK];
  assign otRelease = autoRec && !otsdS;

  // Non-thermal faults hold the pin until cleared.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      errOther_q <= 1'b0;
    end else begin
      errOther_q <= errSet || (errOther_q && !errorClear);
    end
  end

  // Thermal shutdown also lets go once the device recovers itself.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      errOtsd_q <= 1'b0;
    end else begin
      errOtsd_q <= otsdEv && !pinCtl_q[PM_OVERTEMP_SHUTDOWN] ||
                   errOtsd_q && !errorClear && !otRelease;
    end
  end

  // Caution pin latches; power-on asserts it from reset.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      caution_q <= 1'b1;
    end else begin
      caution_q <= clipNow && !pinCtl_q[PM_CLIP] ||
                   otwEv && !pinCtl_q[PM_OTW] ||
                   capEv && !pinCtl_q[PM_ILIM] ||
                   caution_q && !errorClear;
    end
  end

  // Open-drain pins: drive low when active.
  assign errorAlertNO = 1'b0;
  assign errorAlertNOe = errOther_q || errOtsd_q;
  assign cautionAlertNO = 1'b0;
  assign cautionAlertNOe = caution_q;

  // ===================================================================
  // Protective holds and operating state
  // ===================================================================
  logic chHold_q, otHold_q, forceHiZ;
  logic [RW-1:0] rampCnt_q;

  // Channel shutdown waits for software; thermal may self-recover.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      chHold_q <= 1'b0;
      otHold_q <= 1'b0;
    end else begin
      chHold_q <= ocEv || dcEv || (chHold_q && !errorClear);
      otHold_q <= otsdEv ||
                  otHold_q && !errorClear && !otRelease;
    end
  end
  // Supply faults force Hi-Z while present.
  assign forceHiZ = chHold_q || otHold_q || voltEv;

  // Next state: ramp first when the standby pin drops in a switching state.
  always_comb begin
    opState_d = opState_q;
    case (opState_q)
      ST_RAMP: begin
        if (rampCnt_q == '0) begin
          opState_d = ST_STANDBY;
        end
      end
      default: begin
        if (!stbyNS) begin
          opState_d = drive ? ST_RAMP : ST_STANDBY;
        end else if (forceHiZ || stateCtl_q[1:0] == CMD_HIZ) begin
          opState_d = ST_HIZ;
        end else if (&stateCtl_q[1:0]) begin
          opState_d = ST_STANDBY;
        end else if (!muteNS || stateCtl_q[1:0] == CMD_MUTE) begin
          opState_d = ST_MUTE;
        end else begin
          opState_d = ST_PLAY;
        end
      end
    endcase
  end

  // State register; reset is the power-on standby.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      opState_q <= ST_STANDBY;
    end else begin
      opState_q <= opState_d;
    end
  end

  // Ramp timer bounds the ramp-down to the limit.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rampCnt_q <= '0;
    end else if (opState_q != ST_RAMP) begin
      rampCnt_q <= RW'(RAMP_CYC - 1);
    end else if (rampCnt_q != '0) begin
      rampCnt_q <= rampCnt_q - RW'(1);
    end
  end

  assign opState = opState_q;
  assign outputsHiZ = (opState_q == ST_STANDBY) || (opState_q == ST_HIZ);
  assign outputsMute = (opState_q == ST_MUTE) || (opState_q == ST_RAMP);
  assign rampDown = (opState_q == ST_RAMP);
  assign oscRun = (opState_q != ST_STANDBY);

  // ===================================================================
  // Serial target
  // ===================================================================
  fwsc_i2c_t ph_q, next_q;
  logic [7:0] shift_q, ptr_q, rdByte, devAddr;
  logic [3:0] bitCnt_q;
  logic startDet, stopDet, sclRise, sclFall;

  assign devAddr = WR_ADDR_BASE + {5'h00, addrS, 1'b0};
  assign startDet = sclS && sclD_q && sdaD_q && !sdaS;
  assign stopDet = sclS && sclD_q && !sdaD_q && sdaS;
  assign sclRise = sclS && !sclD_q;
  assign sclFall = !sclS && sclD_q;

  // Read data at the current subaddress.
  always_comb begin
    case (ptr_q)
      REG_MISC1: rdByte = misc1_q;
      REG_STATE: rdByte = stateCtl_q;
      REG_CHREP: rdByte = {5'h00, opState_q};
      REG_CHFLT: rdByte = {6'h00, stat_q[1:0]};
      REG_GFLT1: rdByte = {3'h0, stat_q[6:2]};
      REG_GFLT2: rdByte = {7'h00, stat_q[7]};
      REG_WARN: rdByte = {5'h00, porStat_q, stat_q[9:8]};
      REG_PINCTL: rdByte = pinCtl_q;
      REG_MISC3: rdByte = misc3_q;
      REG_CLIPCTL: rdByte = clipCtl_q;
      REG_CLIPWIN: rdByte = clipWin_q;
      REG_CLIPWRN: rdByte = {7'h00, clipStat_q};
      REG_ILIM: rdByte = {7'h00, stat_q[10]};
      default: rdByte = 8'h00;
    endcase
  end

  // Byte engine: samples on rising clock; changes phase and shifts read data on falling.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ph_q <= IS_IDLE;
      next_q <= IS_IDLE;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      bitCnt_q <= 4'h0;
      wrEn_q <= 1'b0;
      wrAddr_q <= 8'h00;
      wrData_q <= 8'h00;
    end else begin
      wrEn_q <= 1'b0;
      if (startDet) begin
        ph_q <= IS_ADDR;
        bitCnt_q <= 4'h0;
      end else if (stopDet) begin
        ph_q <= IS_IDLE;
      end else if (sclRise) begin
        if (ph_q == IS_ADDR || ph_q == IS_SUB || ph_q == IS_WDATA) begin
          shift_q <= {shift_q[6:0], sdaS};
          bitCnt_q <= bitCnt_q + 4'h1;
        end else if (ph_q == IS_RACK) begin
          next_q <= sdaS ? IS_IDLE : IS_RDATA;
        end
      end else if (sclFall) begin
        case (ph_q)
          IS_ADDR, IS_SUB, IS_WDATA: begin
            if (bitCnt_q == 4'h8) begin
              bitCnt_q <= 4'h0;
              ph_q <= IS_ACK;
              if (ph_q == IS_ADDR) begin
                if (shift_q[7:1] != devAddr[7:1]) begin
                  ph_q <= IS_IDLE;
                end
                next_q <= shift_q[0] ? IS_RDATA : IS_SUB;
              end else if (ph_q == IS_SUB) begin
                ptr_q <= shift_q;
                next_q <= IS_WDATA;
              end else begin
                wrEn_q <= 1'b1;
                wrAddr_q <= ptr_q;
                wrData_q <= shift_q;
                ptr_q <= ptr_q + 8'h01;
                next_q <= IS_WDATA;
              end
            end
          end
          IS_ACK, IS_RACK: begin
            ph_q <= next_q;
            bitCnt_q <= 4'h0;
            if (next_q == IS_RDATA) begin
              shift_q <= rdByte;
              ptr_q <= ptr_q + 8'h01;
            end
          end
          IS_RDATA: begin
            shift_q <= {shift_q[6:0], 1'b0};
            bitCnt_q <= bitCnt_q + 4'h1;
            if (bitCnt_q == 4'h7) begin
              ph_q <= IS_RACK;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Only pulls data low; the clock line is never driven.
  assign sdaPinO = 1'b0;
  assign sdaPinOe = (ph_q == IS_ACK) ||
                    (ph_q == IS_RDATA && !shift_q[7]);
endmodule // fwsc_status_ctrl
`default_nettype wire

//--- fwsc_status_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Bench: bus access, alert latching, clip count and state sequencing.
module fwsc_status_ctrl_bench
  import fwsc_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic muteN = 1'b1;
  logic standbyN = 1'b1;
  logic pwmClk = 1'b0;
  logic pwmAtMax = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [10:0] cond = 11'h000;
  logic sdaPinO, sdaPinOe, hostLow, sclPin, errorAlertNO, errorAlertNOe;
  logic cautionAlertNO, cautionAlertNOe, outputsHiZ, outputsMute, rampDown;
  logic oscRun, currentCapLevel;
  logic [2:0] opState;
  logic [1:0] otwThreshold;
  wire sda = !(hostLow || (sdaPinOe && !sdaPinO));
  wire [1:0] pins = {cautionAlertNOe, errorAlertNOe};
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;
  fwsc_i2c_host u_fwsc_i2c_host (.scl(sclPin), .sdaLow(hostLow), .sda);
  fwsc_status_ctrl #(.RAMP_CYC(20)) u_fwsc_status_ctrl (.clk, .sys_rst,
    .sclPin, .sdaPinIn(sda), .sdaPinO, .sdaPinOe, .addressSelectPins(sel),
    .muteN, .standbyN, .chOverCurrent(cond[0]), .chDcDetect(cond[1]),
    .overtempShutdown(cond[2]), .uvBatterySupply(cond[3]),
    .uvOutputStageSupply(cond[4]), .ovBatterySupply(cond[5]),
    .ovOutputStageSupply(cond[6]), .clockError(cond[7]),
    .otCautionGlobal(cond[8]), .otCautionChan(cond[9]),
    .currentCapFlag(cond[10]), .pwmClk, .pwmAtMax, .errorAlertNO,
    .errorAlertNOe, .cautionAlertNO, .cautionAlertNOe, .opState,
    .outputsHiZ, .outputsMute, .rampDown, .oscRun, .otwThreshold,
    .currentCapLevel);
  always #4 clk = !clk;
  // A hang counts as a mismatch and ends the run.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Address byte, subaddress, then n data bytes from the top of d.
  task automatic wr(input logic [7:0] s, input logic [15:0] d, input int n);
    logic [7:0] q;
    logic k;
    u_fwsc_i2c_host.start();
    u_fwsc_i2c_host.xfer(WR_ADDR_BASE + 8'({sel, 1'b0}), 1'b1, q, k);
    chk(8'(k), 8'h01);
    u_fwsc_i2c_host.xfer(s, 1'b1, q, k);
    for (int j = 0; j < n; j++) begin
      u_fwsc_i2c_host.xfer(d[15 - 8 * j -: 8], 1'b1, q, k);
    end
    u_fwsc_i2c_host.stop();
    cyc(12);
  endtask
  task automatic rd(input logic [7:0] s, output logic [7:0] q);
    logic k;
    logic [7:0] a;
    a = WR_ADDR_BASE + 8'({sel, 1'b0});
    u_fwsc_i2c_host.start();
    u_fwsc_i2c_host.xfer(a, 1'b1, q, k);
    u_fwsc_i2c_host.xfer(s, 1'b1, q, k);
    u_fwsc_i2c_host.start();
    u_fwsc_i2c_host.xfer(a | 8'h01, 1'b1, q, k);
    u_fwsc_i2c_host.xfer(8'hFF, 1'b1, q, k);
    u_fwsc_i2c_host.stop();
  endtask
  task automatic clr();
    wr(REG_MISC3, 16'h8000, 1);
  endtask
  task automatic t_reset();
    logic [7:0] q;
    chk(8'(cautionAlertNOe), 8'h01);
    chk(8'(otwThreshold), 8'h01);
    chk(8'(currentCapLevel), 8'h01);
    chk(8'({sdaPinO, errorAlertNO, cautionAlertNO}), 8'h00);
    rd(REG_CLIPWIN, q);
    chk(q, 8'h14);
    clr();
    chk(8'(cautionAlertNOe), 8'h00);
    rd(REG_MISC3, q);
    chk(q, 8'h00);
    $display("t_reset done");
  endtask
  // Each select value answers its own address and ignores a neighbour's.
  task automatic t_addr();
    logic [7:0] q;
    logic k;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) sel <= 2'(i);
      cyc(4);
      u_fwsc_i2c_host.start();
      u_fwsc_i2c_host.xfer(8'hD4 + 8'(2 * i), 1'b1, q, k);
      u_fwsc_i2c_host.stop();
      chk(8'(k), 8'h01);
      u_fwsc_i2c_host.start();
      u_fwsc_i2c_host.xfer(8'hD4 + 8'(2 * ((i + 1) % 4)), 1'b1, q, k);
      u_fwsc_i2c_host.stop();
      chk(8'(k), 8'h00);
    end
    $display("t_addr done");
  endtask
  task automatic pw(input int n);
    repeat (n) begin
      @(posedge clk) pwmClk <= 1'b1;
      cyc(4);
      @(posedge clk) pwmClk <= 1'b0;
      cyc(4);
    end
  endtask
  task automatic t_clip();
    logic [7:0] q;
    wr(REG_CLIPCTL, 16'h0005, 2);
    @(posedge clk) pwmAtMax <= 1'b1;
    pw(4);
    chk(8'(cautionAlertNOe), 8'h00);
    pw(1);
    chk(8'(cautionAlertNOe), 8'h01);
    @(posedge clk) pwmAtMax <= 1'b0;
    rd(REG_CLIPWRN, q);
    chk(q, 8'h01);
    rd(REG_CLIPWIN, q);
    chk(q, 8'h05);
    clr();
    rd(REG_CLIPWRN, q);
    chk(q, 8'h00);
    $display("t_clip done");
  endtask
  // Every fault and warning input: set, clear while standing, drop, clear.
  task automatic t_alerts();
    logic [7:0] q;
    for (int i = 0; i < 11; i++) begin
      @(posedge clk) cond <= 11'h001 << i;
      cyc(12);
      chk(8'(pins[i >= 8]), 8'h01);
      if (i != 7) chk(8'(outputsHiZ), 8'(i < 7));
      clr();
      chk(8'(pins[i >= 8]), 8'h01);
      @(posedge clk) cond <= 11'h000;
      cyc(12);
      chk(8'(pins[i >= 8]), 8'h01);
      clr();
      chk(8'(pins), 8'h00);
      chk(8'(opState), 8'(ST_PLAY));
    end
    // Auto-recovery releases the thermal alert.
    wr(REG_MISC3, 16'h0800, 1);
    @(posedge clk) cond <= 11'h004;
    cyc(12);
    @(posedge clk) cond <= 11'h000;
    cyc(12);
    chk(8'(pins), 8'h00);
    chk(8'(opState), 8'(ST_PLAY));
    clr();
    // A masked channel fault still acts and reports.
    wr(REG_PINCTL, 16'h0100, 1);
    @(posedge clk) cond <= 11'h001;
    cyc(12);
    chk(8'(pins), 8'h00);
    chk(8'(outputsHiZ), 8'h01);
    @(posedge clk) cond <= 11'h000;
    rd(REG_CHFLT, q);
    chk(q, 8'h01);
    clr();
    $display("t_alerts done");
  endtask
  task automatic t_state();
    @(posedge clk) muteN <= 1'b0;
    cyc(12);
    chk(8'(opState), 8'(ST_MUTE));
    chk(8'(outputsMute), 8'h01);
    @(posedge clk) muteN <= 1'b1;
    cyc(12);
    wr(REG_STATE, 16'h0200, 1);
    chk(8'(opState), 8'(ST_MUTE));
    wr(REG_STATE, 16'h0300, 1);
    chk(8'(opState), 8'(ST_STANDBY));
    wr(REG_STATE, 16'h0000, 1);
    @(posedge clk) standbyN <= 1'b0;
    cyc(8);
    chk(8'(rampDown), 8'h01);
    for (int n = 0; n < 40 && opState !== ST_STANDBY; n++) cyc(1);
    chk(8'(opState), 8'(ST_STANDBY));
    chk(8'(oscRun), 8'h00);
    $display("t_state done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    cyc(6);
    t_reset();
    t_addr();
    t_clip();
    t_alerts();
    t_state();
    close_out();
  end
endmodule // fwsc_status_ctrl_bench
`default_nettype wire

//--- fwsc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Two-stage synchroniser for pins from outside the clock domain.
module fwsc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  // First stage is read only by the second stage.
  logic [WIDTH-1:0] meta_q;

  // Both stages clear on reset and then follow the pins.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // fwsc_sync
`default_nettype wire
